// ### common/adc_ctl_pkg.sv
// Package with register map, fields and timing for the converter sequencer
// What this block does
// - Single mode converts only the one selected channel, 12-bit result
// - Eight external inputs plus temperature and battery internal inputs
// - Cycling mode steps through a chosen channel set without software help
// - Temperature and battery inputs are never part of a cycling sequence
// - Each channel, internal ones too, keeps its own latest result register
// - Optional averaging of up to 256 samples, reporting the mean
// - Comparator alerts when a result is above high or below low threshold
// - Threshold checking only on external inputs 0 to 3 and analog_in_zero
// - Alert clears only after hysteresis count plus one in-range conversions, up to nine
// - DMA mode streams results; one interrupt after the programmed count
// - Update rate programmable 10 KSPS to 1.8 MSPS by interval divider
// - Internal or external reference; internal offers 1.25 V, 2.5 V, battery
package adc_ctl_pkg;
  localparam int DATA_W = 12;
  localparam int NUM_CH = 10;
  localparam int CH_W   = 4;
  localparam logic [CH_W-1:0] CH_TEMP = 4'h8;
  localparam logic [CH_W-1:0] CH_BATT = 4'h9;
  localparam logic [CH_W-1:0] CH_ANALOG_IN_ZERO = 4'h0;
  // Byte addresses
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_SEQ    = 12'h004;
  localparam logic [11:0] A_RATE   = 12'h008;
  localparam logic [11:0] A_THRHI  = 12'h00C;
  localparam logic [11:0] A_THRLO  = 12'h010;
  localparam logic [11:0] A_HYST   = 12'h014;
  localparam logic [11:0] A_DMACNT = 12'h018;
  localparam logic [11:0] A_STAT   = 12'h01C;
  localparam logic [11:0] A_MASK   = 12'h020;
  localparam logic [11:0] A_DONE   = 12'h024;
  localparam logic [11:0] A_RES0   = 12'h040;
  // Control fields
  localparam int C_START  = 0;
  localparam int C_AUTO   = 1;
  localparam int C_AVG    = 2;
  localparam int C_DMA    = 3;
  localparam int C_WRAP   = 4;
  localparam int C_REFEXT = 5;
  localparam int C_REFSEL = 6;
  localparam int C_CHSEL  = 8;
  localparam int C_AVGLOG = 12;
  localparam int C_CMPEN  = 16;
  // Status bits
  localparam int S_DONE  = 0;
  localparam int S_ALERT = 1;
  localparam int S_DMA   = 2;
  localparam int S_SEQ   = 3;
  localparam int NUM_IRQ = 4;
  // Reference selection codes
  localparam logic [1:0] REF_1V25 = 2'h0;
  localparam logic [1:0] REF_2V5  = 2'h1;
  localparam logic [1:0] REF_VBAT = 2'h2;
  // Rate limits
  localparam int CLK_HZ      = 25000000;
  localparam int RATE_MIN_SPS = 10000;
  localparam int RATE_MAX_SPS = 1800000;
  localparam int DIV_MIN = (CLK_HZ + RATE_MAX_SPS - 1) / RATE_MAX_SPS;
  localparam int DIV_MAX = CLK_HZ / RATE_MIN_SPS;
  localparam int DIV_W   = 12;
  localparam int AVG_MAX_LOG = 8;
  localparam int HYST_MAX    = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11,
    ST_NEXT = 2'b10
  } state_t;
endpackage

// ### logic/adc_sequencer.sv
// Converter sequencer control with APB registers, DMA stream and interrupts
`timescale 1ns/1ns
module adc_sequencer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             convStart,
  output logic [3:0]       muxSel,
  output logic             refExternal,
  output logic [1:0]       refLevel,
  input  wire logic        convDone,
  input  wire logic [11:0] convData,
  output logic             dmaValid,
  output logic [11:0]      dmaData,
  input  wire logic        dmaReady,
  output logic             irq
);
  localparam int W = adc_ctl_pkg::DATA_W;
  localparam int N = adc_ctl_pkg::NUM_CH;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]  ctrl_q;
  logic [7:0]   seq_q;
  logic [11:0]  rate_q;
  logic [W-1:0] thrHi_q;
  logic [W-1:0] thrLo_q;
  logic [3:0]   hyst_q;
  logic [15:0]  dmaCnt_q;
  logic [3:0]   stat_q;
  logic [3:0]   mask_q;
  logic [N-1:0] done_q;
  logic [W-1:0] res_q [N];
  adc_ctl_pkg::state_t state_q;
  logic [3:0]   ch_q;
  logic [11:0]  divCnt_q;
  logic [19:0]  acc_q;
  logic [8:0]   avgCnt_q;
  logic [15:0]  xfer_q;
  logic [3:0]   clrCnt_q;
  logic         alert_q;
  logic         cdSync1_q;
  logic         cdSync2_q;
  logic         cdPrev_q;
  logic [11:0]  cData1_q;
  logic [11:0]  cData2_q;

  logic wr;
  logic rd;
  logic cdRise;
  logic resultEv;
  logic [W-1:0] mean;
  logic [8:0]   avgN;
  logic         lastCh;
  logic [3:0]   nextCh;
  logic         evAlert;
  logic         evDma;
  logic         evSeq;
  logic [11:0]  divLim;

  // Next enabled channel after the given one, external inputs only
  function automatic logic [3:0] next_seq(input logic [3:0] c,
                                          input logic [7:0] m);
    logic [3:0] r;
    logic       f;
    r = c;
    f = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      if (!f && m[(int'(c) + i) % 8]) begin
        r = 4'((int'(c) + i) % 8);
        f = 1'b1;
      end
    end
    return r;
  endfunction

  // First enabled channel of the set
  function automatic logic [3:0] first_seq(input logic [7:0] m);
    return next_seq(4'h7, m);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign refExternal = ctrl_q[adc_ctl_pkg::C_REFEXT];
  assign refLevel = ctrl_q[adc_ctl_pkg::C_REFSEL +: 2];
  assign muxSel = ch_q;
  assign avgN = ctrl_q[adc_ctl_pkg::C_AVG] ?
                9'(9'h001 << ctrl_q[adc_ctl_pkg::C_AVGLOG +: 4]) : 9'h001;
  assign divLim = (rate_q < 12'(adc_ctl_pkg::DIV_MIN)) ?
                  12'(adc_ctl_pkg::DIV_MIN) :
                  (rate_q > 12'(adc_ctl_pkg::DIV_MAX)) ?
                  12'(adc_ctl_pkg::DIV_MAX) : rate_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converter done synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      cdSync1_q <= 1'b0;
      cdSync2_q <= 1'b0;
      cdPrev_q  <= 1'b0;
      cData1_q  <= 12'h000;
      cData2_q  <= 12'h000;
    end else begin
      cdSync1_q <= convDone;
      cdSync2_q <= cdSync1_q;
      cdPrev_q  <= cdSync2_q;
      cData1_q  <= convData;
      cData2_q  <= cData1_q;
    end
  end
  assign cdRise = cdSync2_q && !cdPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q   <= 32'h0000_0000;
      seq_q    <= 8'h00;
      rate_q   <= 12'(adc_ctl_pkg::DIV_MAX);
      thrHi_q  <= 12'hFFF;
      thrLo_q  <= 12'h000;
      hyst_q   <= 4'h0;
      dmaCnt_q <= 16'h0000;
      mask_q   <= 4'h0;
    end else begin
      if (state_q != adc_ctl_pkg::ST_IDLE || !ctrl_q[adc_ctl_pkg::C_START])
        ctrl_q[adc_ctl_pkg::C_START] <= ctrl_q[adc_ctl_pkg::C_START] &&
                                        state_q == adc_ctl_pkg::ST_IDLE;
      if (wr) begin
        case (paddr)
          adc_ctl_pkg::A_CTRL:   ctrl_q   <= pwdata;
          adc_ctl_pkg::A_SEQ:    seq_q    <= pwdata[7:0];
          adc_ctl_pkg::A_RATE:   rate_q   <= pwdata[11:0];
          adc_ctl_pkg::A_THRHI:  thrHi_q  <= pwdata[11:0];
          adc_ctl_pkg::A_THRLO:  thrLo_q  <= pwdata[11:0];
          adc_ctl_pkg::A_HYST:   hyst_q   <= (pwdata[3:0] > 4'h8) ?
                                             4'h8 : pwdata[3:0];
          adc_ctl_pkg::A_DMACNT: dmaCnt_q <= pwdata[15:0];
          adc_ctl_pkg::A_MASK:   mask_q   <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign lastCh = !ctrl_q[adc_ctl_pkg::C_AUTO] ||
                  next_seq(ch_q, seq_q) <= ch_q;
  assign nextCh = next_seq(ch_q, seq_q);
  assign resultEv = state_q == adc_ctl_pkg::ST_CONV && cdRise &&
                    avgCnt_q + 9'h001 >= avgN;
  assign mean = 12'((acc_q + 20'(cData2_q)) >>
                (ctrl_q[adc_ctl_pkg::C_AVG] ?
                 ctrl_q[adc_ctl_pkg::C_AVGLOG +: 4] : 4'h0));
  assign evSeq = resultEv && lastCh && ctrl_q[adc_ctl_pkg::C_AUTO];

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= adc_ctl_pkg::ST_IDLE;
      ch_q      <= 4'h0;
      divCnt_q  <= 12'h000;
      acc_q     <= 20'h00000;
      avgCnt_q  <= 9'h000;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (state_q)
        adc_ctl_pkg::ST_IDLE: begin
          if (ctrl_q[adc_ctl_pkg::C_START]) begin
            ch_q <= ctrl_q[adc_ctl_pkg::C_AUTO] ? first_seq(seq_q)
                  : ctrl_q[adc_ctl_pkg::C_CHSEL +: 4];
            acc_q    <= 20'h00000;
            avgCnt_q <= 9'h000;
            divCnt_q <= 12'h000;
            state_q  <= adc_ctl_pkg::ST_WAIT;
          end
        end
        adc_ctl_pkg::ST_WAIT: begin
          divCnt_q <= divCnt_q + 12'h001;
          if (divCnt_q + 12'h001 >= divLim) begin
            divCnt_q  <= 12'h000;
            convStart <= 1'b1;
            state_q   <= adc_ctl_pkg::ST_CONV;
          end
        end
        adc_ctl_pkg::ST_CONV: begin
          divCnt_q <= divCnt_q + 12'h001;
          if (cdRise) begin
            if (resultEv) begin
              acc_q    <= 20'h00000;
              avgCnt_q <= 9'h000;
              state_q  <= adc_ctl_pkg::ST_NEXT;
            end else begin
              acc_q    <= acc_q + 20'(cData2_q);
              avgCnt_q <= avgCnt_q + 9'h001;
              state_q  <= adc_ctl_pkg::ST_WAIT;
            end
          end
        end
        adc_ctl_pkg::ST_NEXT: begin
          if (ctrl_q[adc_ctl_pkg::C_AUTO] && seq_q != 8'h00 &&
              (!lastCh || ctrl_q[adc_ctl_pkg::C_WRAP])) begin
            ch_q    <= nextCh;
            state_q <= adc_ctl_pkg::ST_WAIT;
          end else begin
            state_q <= adc_ctl_pkg::ST_IDLE;
          end
        end
        default: state_q <= adc_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results and done flags
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < N; i++) res_q[i] <= 12'h000;
    end else if (resultEv) begin
      res_q[ch_q] <= mean;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (resultEv && ch_q == 4'(i))
          done_q[i] <= 1'b1;
        else if (wr && paddr == adc_ctl_pkg::A_DONE && pwdata[i])
          done_q[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator with hysteresis
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_q  <= 1'b0;
      clrCnt_q <= 4'h0;
    end else if (resultEv && ctrl_q[adc_ctl_pkg::C_CMPEN] &&
                 ch_q <= 4'h3) begin
      if (mean > thrHi_q || mean < thrLo_q) begin
        alert_q  <= 1'b1;
        clrCnt_q <= 4'h0;
      end else if (alert_q) begin
        if (clrCnt_q >= hyst_q) begin
          alert_q  <= 1'b0;
          clrCnt_q <= 4'h0;
        end else begin
          clrCnt_q <= clrCnt_q + 4'h1;
        end
      end
    end
  end
  assign evAlert = resultEv && ctrl_q[adc_ctl_pkg::C_CMPEN] &&
                   ch_q <= 4'h3 &&
                   (mean > thrHi_q || mean < thrLo_q);

  ////////////////////////////////////////////////////////////////////////////
  // DMA stream
  always_ff @(posedge clk) begin
    if (rst) begin
      dmaValid <= 1'b0;
      dmaData  <= 12'h000;
      xfer_q   <= 16'h0000;
    end else begin
      if (dmaValid && dmaReady) begin
        dmaValid <= 1'b0;
        xfer_q   <= (xfer_q + 16'h0001 >= dmaCnt_q) ? 16'h0000
                    : xfer_q + 16'h0001;
      end
      if (resultEv && ctrl_q[adc_ctl_pkg::C_DMA]) begin
        dmaValid <= 1'b1;
        dmaData  <= mean;
      end
    end
  end
  assign evDma = dmaValid && dmaReady && dmaCnt_q != 16'h0000 &&
                 xfer_q + 16'h0001 >= dmaCnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else begin
      for (int i = 0; i < adc_ctl_pkg::NUM_IRQ; i++) begin
        if ((i == adc_ctl_pkg::S_DONE && resultEv) ||
            (i == adc_ctl_pkg::S_ALERT && evAlert) ||
            (i == adc_ctl_pkg::S_DMA && evDma) ||
            (i == adc_ctl_pkg::S_SEQ && evSeq))
          stat_q[i] <= 1'b1;
        else if (wr && paddr == adc_ctl_pkg::A_STAT && pwdata[i])
          stat_q[i] <= 1'b0;
      end
    end
  end
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        adc_ctl_pkg::A_CTRL:   prdata <= ctrl_q;
        adc_ctl_pkg::A_SEQ:    prdata <= {24'h000000, seq_q};
        adc_ctl_pkg::A_RATE:   prdata <= {20'h00000, rate_q};
        adc_ctl_pkg::A_THRHI:  prdata <= {20'h00000, thrHi_q};
        adc_ctl_pkg::A_THRLO:  prdata <= {20'h00000, thrLo_q};
        adc_ctl_pkg::A_HYST:   prdata <= {28'h0000000, hyst_q};
        adc_ctl_pkg::A_DMACNT: prdata <= {16'h0000, dmaCnt_q};
        adc_ctl_pkg::A_STAT:   prdata <= {27'h0000000, alert_q, stat_q};
        adc_ctl_pkg::A_MASK:   prdata <= {28'h0000000, mask_q};
        adc_ctl_pkg::A_DONE:   prdata <= {22'h000000, done_q};
        default: begin
          for (int i = 0; i < N; i++)
            if (paddr == adc_ctl_pkg::A_RES0 + 12'(4 * i))
              prdata <= {20'h00000, res_q[i]};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_CONV_PULSE: assert property (@(posedge clk) disable iff (rst)
    convStart |=> !convStart) else $error("start not a pulse");
  AST_AUTO_EXT: assert property (@(posedge clk) disable iff (rst)
    (state_q != adc_ctl_pkg::ST_IDLE && ctrl_q[adc_ctl_pkg::C_AUTO])
    |-> ch_q < 4'h8) else $error("internal channel in sequence");
  AST_SINGLE_CH: assert property (@(posedge clk) disable iff (rst)
    (state_q == adc_ctl_pkg::ST_NEXT && !ctrl_q[adc_ctl_pkg::C_AUTO])
    |=> state_q == adc_ctl_pkg::ST_IDLE) else $error("single mode continued");
  AST_RES_UPD: assert property (@(posedge clk) disable iff (rst)
    resultEv |=> res_q[$past(ch_q)] == $past(mean))
    else $error("result not stored");
  AST_DONE_SET: assert property (@(posedge clk) disable iff (rst)
    resultEv |=> done_q[$past(ch_q)] && stat_q[adc_ctl_pkg::S_DONE])
    else $error("done flag not set");
  AST_ALERT: assert property (@(posedge clk) disable iff (rst)
    evAlert |=> alert_q && stat_q[adc_ctl_pkg::S_ALERT])
    else $error("alert missed");
  AST_NO_ALERT_HI: assert property (@(posedge clk) disable iff (rst)
    (resultEv && ch_q > 4'h3) |=> alert_q == $past(alert_q))
    else $error("alert on wrong channel");
  AST_DMA_IRQ: assert property (@(posedge clk) disable iff (rst)
    evDma |=> stat_q[adc_ctl_pkg::S_DMA] && xfer_q == 16'h0000)
    else $error("dma count irq wrong");
  AST_DONE_CLR: assert property (@(posedge clk) disable iff (rst)
    (wr && paddr == adc_ctl_pkg::A_DONE && !resultEv) |=>
    (done_q & $past(pwdata[N-1:0])) == '0) else $error("done not cleared");
endmodule

// ### tb/conv_core_model.sv
// Behavioural converter core with input multiplexer
`timescale 1ns/1ns
module conv_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        convStart,
  input  wire logic [3:0]  muxSel,
  input  wire logic        slowMode,
  input  wire logic        wobble,
  input  wire logic [11:0] sampleBase,
  output logic             convDone,
  output logic [11:0]      convData
);
  logic [5:0]  wait_q;
  logic [2:0]  hold_q;
  logic        busy_q;
  logic        flip_q;
  logic [11:0] val_q;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q   <= 1'b0;
      flip_q   <= 1'b0;
      wait_q   <= 6'h00;
      hold_q   <= 3'h0;
      val_q    <= 12'h000;
      convDone <= 1'b0;
      convData <= 12'hA5A;
    end else if (convStart) begin
      // Sample the selected input, value tied to channel number
      busy_q <= 1'b1;
      convDone <= 1'b0;
      wait_q <= slowMode ? 6'h14 : 6'h02;
      val_q  <= sampleBase + {4'h0, muxSel, 4'h0}
                + ((wobble && flip_q) ? 12'h002 : 12'h000);
      flip_q <= ~flip_q;
    end else if (busy_q) begin
      if (wait_q == 6'h01) begin
        convData <= val_q;
      end
      if (wait_q == 6'h00) begin
        convDone <= 1'b1;
        hold_q   <= 3'h6;
        busy_q   <= 1'b0;
      end else begin
        wait_q <= wait_q - 6'h01;
      end
    end else if (convDone) begin
      if (hold_q == 3'h0) begin
        // Hold over: data no longer valid
        convDone <= 1'b0;
        convData <= ~convData;
      end else begin
        hold_q <= hold_q - 3'h1;
      end
    end
  end
endmodule

// ### tb/sar_adc_sequencer_control_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module sar_adc_sequencer_control_bench;
  localparam logic [11:0] CTRL = adc_ctl_pkg::A_CTRL;
  localparam logic [11:0] STAT = adc_ctl_pkg::A_STAT;
  localparam logic [11:0] DONE = adc_ctl_pkg::A_DONE;
  localparam logic [31:0] GO = 32'h1;
  localparam logic [31:0] AUTO = 32'h2;
  localparam logic [31:0] AVG = 32'h4;
  localparam logic [31:0] DMA = 32'h8;
  localparam logic [31:0] WRAP = 32'h10;
  localparam logic [31:0] EXT = 32'h20;
  localparam logic [31:0] CMP = 32'h10000;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, convStart;
  logic refExternal, convDone, dmaValid, dmaReady, irq, slowMode, wobble;
  logic [11:0] paddr, convData, dmaData, sampleBase, firstWord;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  muxSel, lastCh;
  logic [1:0]  refLevel;
  logic        autoMode, stall;
  int miscompares, check_count, startCnt, badAuto, dmaCnt, cyc, prevCyc;
  int minGap, i;
  adc_sequencer u_adc_sequencer (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convStart(convStart), .muxSel(muxSel), .refExternal(refExternal),
    .refLevel(refLevel), .convDone(convDone), .convData(convData),
    .dmaValid(dmaValid), .dmaData(dmaData), .dmaReady(dmaReady), .irq(irq));
  conv_core_model u_conv_core_model (.clk(clk), .rst(rst),
    .convStart(convStart), .muxSel(muxSel), .slowMode(slowMode),
    .wobble(wobble), .sampleBase(sampleBase), .convDone(convDone),
    .convData(convData));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    dmaReady <= rst ? 1'b0 : (stall ? ~dmaReady : 1'b1);
    if (!rst && convStart) begin
      startCnt++;
      lastCh = muxSel;
      if (autoMode && muxSel >= 4'h8) badAuto++;
      if (cyc - prevCyc < minGap) minGap = cyc - prevCyc;
      prevCyc = cyc;
    end
    if (!rst && dmaValid && dmaReady) begin
      if (dmaCnt == 0) firstWord = dmaData;
      dmaCnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic waitBit(input logic [11:0] a, input int b);
    for (int n = 0; n < 300; n++) begin
      apb(1'b0, a, 32'h0);
      if (v[b] === 1'b1) break;
    end
    chk(v[b], 1'b1);
  endtask
  task automatic conv(input logic [3:0] ch, input logic [31:0] f);
    apb(1'b1, DONE, 32'h1 << ch);
    apb(1'b1, CTRL, GO | f | (32'(ch) << adc_ctl_pkg::C_CHSEL));
    waitBit(DONE, 32'(ch));
  endtask
  task automatic endTest(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2400000;
    miscompares++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, dmaReady} = '0;
    {slowMode, wobble, autoMode, stall} = '0;
    sampleBase = 12'h100;
    {miscompares, check_count, startCnt, badAuto, dmaCnt, cyc} = '0;
    prevCyc = -1000;
    minGap = 1000;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk(adc_ctl_pkg::A_RATE, 32'h9C4);
    rdChk(adc_ctl_pkg::A_THRHI, 32'hFFF);
    apb(1'b1, 12'h0FC, 32'hFFFF);
    rdChk(12'h0FC, 32'h0);
    endTest("reset");
    for (i = 0; i < 3; i++) begin
      apb(1'b1, CTRL, ((i == 1) ? EXT : 0) | (i << adc_ctl_pkg::C_REFSEL));
      @(negedge clk);
      chk({refExternal, refLevel}, {i == 1, i[1:0]});
    end
    endTest("reference");
    apb(1'b1, adc_ctl_pkg::A_RATE, 32'h1);
    apb(1'b1, adc_ctl_pkg::A_MASK, 32'h1);
    for (i = 9; i > 4; i -= 3) begin
      conv(i[3:0], 0);
      chk(lastCh, i[3:0]);
      rdChk(adc_ctl_pkg::A_RES0 + 12'(4 * i), 32'h100 + 16 * i);
      chk(irq, 1'b1);
      apb(1'b1, STAT, 32'h1);
      @(negedge clk);
      chk(irq, 1'b0);
    end
    apb(1'b1, adc_ctl_pkg::A_MASK, 32'h0);
    conv(4'h1, 0);
    chk(irq, 1'b0);
    rdChk(STAT, 32'h1);
    apb(1'b1, STAT, 32'h1F);
    endTest("single");
    sampleBase = 12'h200;
    autoMode = 1'b1;
    startCnt = 0;
    apb(1'b1, adc_ctl_pkg::A_SEQ, 32'h0B);
    apb(1'b1, CTRL, GO | AUTO);
    waitBit(STAT, adc_ctl_pkg::S_SEQ);
    repeat (80) @(posedge clk);
    chk(startCnt, 3);
    chk(badAuto, 0);
    chk(minGap >= adc_ctl_pkg::DIV_MIN, 1);
    for (i = 0; i < 4; i++)
      if (i != 2) rdChk(adc_ctl_pkg::A_RES0 + 12'(4 * i), 32'h200 + 16 * i);
    autoMode = 1'b0;
    endTest("cycling");
    {slowMode, wobble} = 2'b11;
    sampleBase = 12'h300;
    startCnt = 0;
    conv(4'h7, AVG | (32'h2 << adc_ctl_pkg::C_AVGLOG));
    chk(startCnt, 4);
    rdChk(adc_ctl_pkg::A_RES0 + 12'h01C, 32'h371);
    {slowMode, wobble} = 2'b00;
    endTest("average");
    apb(1'b1, adc_ctl_pkg::A_THRHI, 32'h300);
    apb(1'b1, adc_ctl_pkg::A_THRLO, 32'h100);
    apb(1'b1, adc_ctl_pkg::A_HYST, 32'h2);
    apb(1'b1, STAT, 32'h1F);
    sampleBase = 12'h400;
    conv(4'h2, CMP);
    rdChk(STAT, 32'h13);
    apb(1'b1, STAT, 32'h1F);
    conv(4'h5, CMP);
    rdChk(STAT, 32'h11);
    sampleBase = 12'h0C0;
    apb(1'b1, STAT, 32'h1F);
    conv(4'h2, CMP);
    rdChk(STAT, 32'h13);
    sampleBase = 12'h200;
    for (i = 0; i < 3; i++) begin
      conv(4'h2, CMP);
      apb(1'b0, STAT, 32'h0);
      chk(v[4], i < 2);
    end
    endTest("compare");
    apb(1'b1, STAT, 32'h1F);
    apb(1'b1, adc_ctl_pkg::A_DMACNT, 32'h3);
    apb(1'b1, adc_ctl_pkg::A_MASK, 32'h4);
    apb(1'b1, adc_ctl_pkg::A_SEQ, 32'h07);
    sampleBase = 12'h500;
    stall = 1'b1;
    dmaCnt = 0;
    apb(1'b1, CTRL, GO | AUTO | DMA);
    waitBit(STAT, adc_ctl_pkg::S_SEQ);
    repeat (20) @(posedge clk);
    chk(dmaCnt, 3);
    chk(firstWord, 12'h500);
    rdChk(STAT, 32'h0D);
    chk(irq, 1'b1);
    endTest("dma");
    apb(1'b1, STAT, 32'h1F);
    startCnt = 0;
    apb(1'b1, CTRL, GO | AUTO | WRAP);
    waitBit(STAT, adc_ctl_pkg::S_SEQ);
    apb(1'b1, STAT, 32'h8);
    waitBit(STAT, adc_ctl_pkg::S_SEQ);
    chk(startCnt > 3, 1);
    endTest("wrap");
    close_out();
  end
endmodule
